// [hdl/pio_core.sv]
// How it works
// RULE1 - Indirect port: low=port reg, high=counter
// RULE2 - Immediate port: low=port byte, high=accumulator
// RULE3 - Indirect input dest 110 updates flags only
// RULE4 - Block transfer: zero flag from decremented counter
// RULE5 - Block moves memory byte, steps pointer, repeats
// RULE6 - Two flag registers, six meaningful bits each
// RULE7 - Only C, Z, S, P/V are testable conditions
// RULE8 - Carry from MSB on add, borrow, shifts
// RULE9 - Zero flag set on zero result
// RULE10 - Sign flag equals result bit 7
// RULE11 - Overflow on signed range excess
// RULE12 - Logical ops: P/V set on even parity
// RULE13 - Half-carry from low nibble
// RULE14 - Add/subtract flag marks last subtraction
// RULE15 - Flag layout S Z x H x PV N C
// RULE16 - Load I/R copies interrupt enable to P/V
`timescale 1ns/1ps
`include "pio_map.svh"
`default_nettype none
module pio_core #(
    parameter int DEPTH = `PIO_FIFO_DEPTH
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    // Peripheral port
    output logic [15:0]      o_io_addr,
    output logic [7:0]       o_io_wdata,
    output logic             o_io_rd,
    output logic             o_io_wr,
    input  wire logic [7:0]  i_io_rdata,
    input  wire logic        i_io_ready,
    // Memory byte stream
    input  wire logic        i_mem_valid,
    output logic             o_mem_ready,
    input  wire logic [7:0]  i_mem_data,
    output logic             o_mem_valid,
    input  wire logic        i_mem_ready,
    output logic [7:0]       o_mem_data,
    output logic [15:0]      o_mem_addr,
    // Condition test
    input  wire pio_pkg::pio_cc_t i_cc_sel,
    output logic             o_cc_true
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]  flags_reg;
    logic [7:0]  alt_flags_reg;
    logic [7:0]  acc_reg;
    logic [7:0]  cnt_reg;
    logic [7:0]  port_reg;
    logic [7:0]  imm_reg;
    logic [15:0] ptr_reg;
    logic [7:0]  dest_reg;
    logic [7:0]  res_reg;
    logic        ie_reg;
    logic        busy_reg;
    logic        io_rd_reg;
    logic        io_wr_reg;
    logic [15:0] io_addr_reg;
    logic [7:0]  io_wdata_reg;
    logic        mem_valid_reg;
    logic [7:0]  mem_data_reg;
    logic [15:0] mem_addr_reg;
    logic        ack_reg;
    logic [31:0] rdat_reg;
    pio_pkg::pio_op_t  op_reg;
    pio_pkg::pio_alu_t alu_reg;
    logic        down_reg;
    logic        rep_reg;
    logic [2:0]  rsel_reg;
    logic [7:0]  alu_b_reg;

    typedef enum {PIO_IDLE, PIO_ADDR, PIO_WAIT, PIO_MEMRD, PIO_MEMWR, PIO_STEP} pio_st_t;
    pio_st_t st_reg;

    // ----------------------------------------
    // Fifo for block output data
    // ----------------------------------------
    pio_fifo_if #(.W(8)) q();
    pio_fifo #(.W(8), .D(DEPTH)) u_fifo (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .f          (q)
    );

    function automatic logic even_par(input logic [7:0] v);
        even_par = ~^v;
    endfunction : even_par

    // Flag byte for result v with chosen P/V, N, H, C
    function automatic logic [7:0] mk_flags(input logic [7:0] v, input logic pv,
                                            input logic n, input logic h, input logic c);
        logic [7:0] f;
        f = 8'h00;
        f[`PIO_F_S]  = v[7];        // RULE10
        f[`PIO_F_Z]  = (v == 8'h00); // RULE9
        f[`PIO_F_H]  = h;
        f[`PIO_F_PV] = pv;
        f[`PIO_F_N]  = n;
        f[`PIO_F_C]  = c;
        mk_flags = f;               // RULE15
    endfunction : mk_flags

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    logic wb_req;
    logic wb_wr;
    assign wb_req = i_wb_cyc && i_wb_stb && !ack_reg;
    assign wb_wr  = wb_req && i_wb_we && i_wb_sel[0];
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= wb_req;
            case (i_wb_adr)
                `PIO_OFS_FLAGS:     rdat_reg <= {24'h0, flags_reg};
                `PIO_OFS_ALT_FLAGS: rdat_reg <= {24'h0, alt_flags_reg};
                `PIO_OFS_REGS:      rdat_reg <= {acc_reg, cnt_reg, port_reg, imm_reg};
                `PIO_OFS_PTR:       rdat_reg <= {16'h0, ptr_reg};
                `PIO_OFS_STATUS:    rdat_reg <= {16'h0, res_reg, 7'h0, busy_reg};
                `PIO_OFS_IE:        rdat_reg <= {31'h0, ie_reg};
                default:            rdat_reg <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Condition select
    // ----------------------------------------
    always_comb begin
        case (i_cc_sel)                                      // RULE7
            pio_pkg::PIO_CC_Z:  o_cc_true = flags_reg[`PIO_F_Z];
            pio_pkg::PIO_CC_C:  o_cc_true = flags_reg[`PIO_F_C];
            pio_pkg::PIO_CC_PV: o_cc_true = flags_reg[`PIO_F_PV];
            pio_pkg::PIO_CC_S:  o_cc_true = flags_reg[`PIO_F_S];
            default:            o_cc_true = 1'b0;
        endcase
    end

    // ----------------------------------------
    // ALU flag result
    // ----------------------------------------
    logic [8:0] sum;
    logic [4:0] hsum;
    logic [7:0] alu_res;
    logic [7:0] alu_flags;
    always_comb begin
        sum = 9'h000;
        hsum = 5'h00;
        alu_res = 8'h00;
        alu_flags = 8'h00;
        case (alu_reg)
            pio_pkg::PIO_ALU_ADD: begin
                sum  = {1'b0, acc_reg} + {1'b0, alu_b_reg};
                hsum = {1'b0, acc_reg[3:0]} + {1'b0, alu_b_reg[3:0]};
                alu_res = sum[7:0];
                alu_flags = mk_flags(alu_res,                                 // RULE11
                    (acc_reg[7] == alu_b_reg[7]) && (alu_res[7] != acc_reg[7]),
                    1'b0, hsum[4], sum[8]);                                   // RULE8 RULE13 RULE14
            end
            pio_pkg::PIO_ALU_SUB: begin
                sum  = {1'b0, acc_reg} - {1'b0, alu_b_reg};
                hsum = {1'b0, acc_reg[3:0]} - {1'b0, alu_b_reg[3:0]};
                alu_res = sum[7:0];
                alu_flags = mk_flags(alu_res,                                 // RULE11
                    (acc_reg[7] != alu_b_reg[7]) && (alu_res[7] != acc_reg[7]),
                    1'b1, hsum[4], sum[8]);                                   // RULE8 RULE13 RULE14
            end
            pio_pkg::PIO_ALU_AND: begin
                alu_res = acc_reg & alu_b_reg;
                alu_flags = mk_flags(alu_res, even_par(alu_res), 1'b0, 1'b1, 1'b0); // RULE12
            end
            pio_pkg::PIO_ALU_OR: begin
                alu_res = acc_reg | alu_b_reg;
                alu_flags = mk_flags(alu_res, even_par(alu_res), 1'b0, 1'b0, 1'b0); // RULE12
            end
            pio_pkg::PIO_ALU_XOR: begin
                alu_res = acc_reg ^ alu_b_reg;
                alu_flags = mk_flags(alu_res, even_par(alu_res), 1'b0, 1'b0, 1'b0); // RULE12
            end
            pio_pkg::PIO_ALU_RL: begin
                alu_res = {acc_reg[6:0], flags_reg[`PIO_F_C]};
                alu_flags = mk_flags(alu_res, even_par(alu_res), 1'b0, 1'b0, acc_reg[7]); // RULE8
            end
            pio_pkg::PIO_ALU_RR: begin
                alu_res = {flags_reg[`PIO_F_C], acc_reg[7:1]};
                alu_flags = mk_flags(alu_res, even_par(alu_res), 1'b0, 1'b0, acc_reg[0]); // RULE8
            end
            default: begin
                alu_res = acc_reg;
                alu_flags = flags_reg;
            end
        endcase
    end

    // ----------------------------------------
    // Execution sequencer
    // ----------------------------------------
    logic       go;
    logic [7:0] cnt_dec;
    assign go      = wb_wr && (i_wb_adr == `PIO_OFS_CMD) && !busy_reg;
    assign cnt_dec = cnt_reg - 8'h01;

    assign q.in_valid  = i_mem_valid && st_reg == PIO_IDLE;
    assign q.in_data   = i_mem_data;
    assign o_mem_ready = q.in_ready && st_reg == PIO_IDLE;
    assign q.out_ready = (st_reg == PIO_MEMRD) && op_reg == pio_pkg::PIO_OP_BLK_OUT;

    assign o_io_addr  = io_addr_reg;
    assign o_io_wdata = io_wdata_reg;
    assign o_io_rd    = io_rd_reg;
    assign o_io_wr    = io_wr_reg;
    assign o_mem_valid = mem_valid_reg;
    assign o_mem_data  = mem_data_reg;
    assign o_mem_addr  = mem_addr_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            st_reg <= PIO_IDLE;
            busy_reg <= 1'b0;
            op_reg <= pio_pkg::PIO_OP_NOP;
            alu_reg <= pio_pkg::PIO_ALU_ADD;
            down_reg <= 1'b0;
            rep_reg <= 1'b0;
            rsel_reg <= 3'h0;
            alu_b_reg <= 8'h00;
            flags_reg <= `PIO_FLAGS_RST;
            alt_flags_reg <= `PIO_FLAGS_RST;
            acc_reg <= 8'h00;
            cnt_reg <= 8'h00;
            port_reg <= 8'h00;
            imm_reg <= 8'h00;
            ptr_reg <= 16'h0000;
            dest_reg <= 8'h00;
            res_reg <= 8'h00;
            ie_reg <= 1'b0;
            io_rd_reg <= 1'b0;
            io_wr_reg <= 1'b0;
            io_addr_reg <= 16'h0000;
            io_wdata_reg <= 8'h00;
            mem_valid_reg <= 1'b0;
            mem_data_reg <= 8'h00;
            mem_addr_reg <= 16'h0000;
        end else begin
            if (wb_wr && st_reg == PIO_IDLE) begin
                case (i_wb_adr)
                    `PIO_OFS_FLAGS:     flags_reg <= i_wb_dat[7:0] & `PIO_FLAGS_MASK;     // RULE6
                    `PIO_OFS_ALT_FLAGS: alt_flags_reg <= i_wb_dat[7:0] & `PIO_FLAGS_MASK; // RULE6
                    `PIO_OFS_REGS: begin
                        {acc_reg, cnt_reg, port_reg, imm_reg} <= i_wb_dat;
                    end
                    `PIO_OFS_PTR:       ptr_reg <= i_wb_dat[15:0];
                    `PIO_OFS_IE:        ie_reg <= i_wb_dat[0];
                    default: ;
                endcase
            end
            if (go) begin
                op_reg    <= pio_pkg::pio_op_t'(i_wb_dat[3:0]);
                alu_reg   <= pio_pkg::pio_alu_t'(i_wb_dat[6:4]);
                down_reg  <= i_wb_dat[8];
                rep_reg   <= i_wb_dat[9];
                rsel_reg  <= i_wb_dat[12:10];
                alu_b_reg <= i_wb_dat[23:16];
                busy_reg  <= 1'b1;
                st_reg    <= PIO_ADDR;
            end
            case (st_reg)
                PIO_IDLE: ;
                PIO_ADDR: begin
                    case (op_reg)
                        pio_pkg::PIO_OP_IN_IMM, pio_pkg::PIO_OP_OUT_IMM:
                            io_addr_reg <= {acc_reg, imm_reg};  // RULE2
                        default:
                            io_addr_reg <= {cnt_reg, port_reg}; // RULE1
                    endcase
                    io_wdata_reg <= (op_reg == pio_pkg::PIO_OP_OUT_REG) ? alu_b_reg : acc_reg;
                    st_reg <= PIO_WAIT;
                    case (op_reg)
                        pio_pkg::PIO_OP_IN_IMM, pio_pkg::PIO_OP_IN_REG, pio_pkg::PIO_OP_BLK_IN:
                            io_rd_reg <= 1'b1;
                        pio_pkg::PIO_OP_OUT_IMM, pio_pkg::PIO_OP_OUT_REG:
                            io_wr_reg <= 1'b1;
                        pio_pkg::PIO_OP_BLK_OUT: begin
                            st_reg <= PIO_MEMRD;
                        end
                        pio_pkg::PIO_OP_ALU: begin
                            acc_reg <= alu_res;
                            flags_reg <= alu_flags;
                            st_reg <= PIO_IDLE;
                            busy_reg <= 1'b0;
                        end
                        pio_pkg::PIO_OP_LD_IR: begin
                            acc_reg <= alu_b_reg;
                            flags_reg <= mk_flags(alu_b_reg, ie_reg, 1'b0, 1'b0,
                                                  flags_reg[`PIO_F_C]); // RULE16
                            st_reg <= PIO_IDLE;
                            busy_reg <= 1'b0;
                        end
                        default: begin
                            st_reg <= PIO_IDLE;
                            busy_reg <= 1'b0;
                        end
                    endcase
                end
                PIO_MEMRD: begin
                    if (q.out_valid) begin
                        io_wdata_reg <= q.out_data; // RULE5
                        io_wr_reg <= 1'b1;
                        st_reg <= PIO_WAIT;
                    end
                end
                PIO_WAIT: begin
                    if (i_io_ready) begin
                        io_rd_reg <= 1'b0;
                        io_wr_reg <= 1'b0;
                        case (op_reg)
                            pio_pkg::PIO_OP_IN_IMM: begin
                                acc_reg <= i_io_rdata;
                                st_reg <= PIO_IDLE;
                                busy_reg <= 1'b0;
                            end
                            pio_pkg::PIO_OP_IN_REG: begin
                                flags_reg <= mk_flags(i_io_rdata, even_par(i_io_rdata), 1'b0,
                                                      1'b0, flags_reg[`PIO_F_C]);
                                if (rsel_reg != `PIO_DEST_FLAGS) begin // RULE3
                                    dest_reg <= i_io_rdata;
                                end
                                res_reg <= i_io_rdata;
                                st_reg <= PIO_IDLE;
                                busy_reg <= 1'b0;
                            end
                            pio_pkg::PIO_OP_BLK_IN: begin
                                mem_data_reg <= i_io_rdata; // RULE5
                                mem_addr_reg <= ptr_reg;
                                mem_valid_reg <= 1'b1;
                                st_reg <= PIO_MEMWR;
                            end
                            pio_pkg::PIO_OP_BLK_OUT: st_reg <= PIO_STEP;
                            default: begin
                                st_reg <= PIO_IDLE;
                                busy_reg <= 1'b0;
                            end
                        endcase
                    end
                end
                PIO_MEMWR: begin
                    if (i_mem_ready) begin
                        mem_valid_reg <= 1'b0;
                        st_reg <= PIO_STEP;
                    end
                end
                PIO_STEP: begin
                    cnt_reg <= cnt_dec;                                    // RULE5
                    ptr_reg <= down_reg ? ptr_reg - 16'h0001 : ptr_reg + 16'h0001;
                    flags_reg[`PIO_F_Z] <= (cnt_dec == 8'h00);             // RULE4
                    flags_reg[`PIO_F_N] <= 1'b1;
                    res_reg <= cnt_dec;
                    if (rep_reg && cnt_dec != 8'h00) begin
                        st_reg <= PIO_ADDR;                                // RULE5
                    end else begin
                        st_reg <= PIO_IDLE;
                        busy_reg <= 1'b0;
                    end
                end
                default: st_reg <= PIO_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_step_zero_flag: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE4
        st_reg == PIO_STEP |=> flags_reg[`PIO_F_Z] == (cnt_reg == 8'h00))
        else $error("zero flag does not follow counter");
    a_indirect_addr: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE1
        (st_reg == PIO_ADDR && op_reg == pio_pkg::PIO_OP_BLK_IN)
        |=> o_io_addr == {$past(cnt_reg), $past(port_reg)})
        else $error("indirect port address wrong");
    a_imm_addr: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE2
        (st_reg == PIO_ADDR && op_reg == pio_pkg::PIO_OP_IN_IMM)
        |=> o_io_addr == {$past(acc_reg), $past(imm_reg)})
        else $error("immediate port address wrong");
    a_flag_only_in: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE3
        (st_reg == PIO_WAIT && i_io_ready && op_reg == pio_pkg::PIO_OP_IN_REG
         && rsel_reg == `PIO_DEST_FLAGS) |=> $stable(dest_reg))
        else $error("dest written for flags-only input");
    a_ptr_step: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE5
        st_reg == PIO_STEP |=> ptr_reg == ($past(down_reg) ? $past(ptr_reg) - 16'h0001
                                                           : $past(ptr_reg) + 16'h0001))
        else $error("pointer not stepped");
    a_undef_bits: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE6
        (flags_reg & ~`PIO_FLAGS_MASK) == 8'h00)
        else $error("unused flag bits set");
    a_sign_zero: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE10
        (st_reg == PIO_ADDR && op_reg == pio_pkg::PIO_OP_ALU)
        |=> flags_reg[`PIO_F_S] == acc_reg[7] && flags_reg[`PIO_F_Z] == (acc_reg == 8'h00))
        else $error("sign or zero flag wrong");
    a_ie_to_pv: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE16
        (st_reg == PIO_ADDR && op_reg == pio_pkg::PIO_OP_LD_IR)
        |=> flags_reg[`PIO_F_PV] == $past(ie_reg))
        else $error("interrupt enable not copied");
endmodule : pio_core
`default_nettype wire

// [hdl/pio_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module pio_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    pio_fifo_if.fifo  f
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    logic          push;
    logic          pop;

    assign f.in_ready  = (cnt_reg != (AW+1)'(D));
    assign f.out_valid = (cnt_reg != '0);
    assign f.out_data  = mem[rd_reg];
    assign push = f.in_valid && f.in_ready;
    assign pop  = f.out_valid && f.out_ready;

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_reg] <= f.in_data;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : pio_fifo
`default_nettype wire

// [inc/pio_fifo_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pio_fifo_if #(parameter int W = 8);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : pio_fifo_if
`default_nettype wire

// [inc/pio_map.svh]
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH
// ----------------------------------------
// Register offsets (32-bit word addresses)
// ----------------------------------------
`define PIO_OFS_FLAGS      4'h0
`define PIO_OFS_ALT_FLAGS  4'h1
`define PIO_OFS_REGS       4'h2
`define PIO_OFS_PTR        4'h3
`define PIO_OFS_CMD        4'h4
`define PIO_OFS_STATUS     4'h5
`define PIO_OFS_IE         4'h6
// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define PIO_F_S            7
`define PIO_F_Z            6
`define PIO_F_H            4
`define PIO_F_PV           2
`define PIO_F_N            1
`define PIO_F_C            0
`define PIO_FLAGS_MASK     8'hd7
`define PIO_FLAGS_RST      8'h00
`define PIO_DEST_FLAGS     3'h6
`define PIO_FIFO_DEPTH     16
`endif

// [inc/pio_pkg.sv]
package pio_pkg;
    typedef enum logic [3:0] {
        PIO_OP_IN_IMM,
        PIO_OP_IN_REG,
        PIO_OP_OUT_IMM,
        PIO_OP_OUT_REG,
        PIO_OP_BLK_IN,
        PIO_OP_BLK_OUT,
        PIO_OP_ALU,
        PIO_OP_LD_IR,
        PIO_OP_NOP
    } pio_op_t;
    typedef enum logic [2:0] {
        PIO_ALU_ADD,
        PIO_ALU_SUB,
        PIO_ALU_AND,
        PIO_ALU_OR,
        PIO_ALU_XOR,
        PIO_ALU_RL,
        PIO_ALU_RR
    } pio_alu_t;
    typedef enum logic [1:0] {
        PIO_CC_Z,
        PIO_CC_C,
        PIO_CC_PV,
        PIO_CC_S
    } pio_cc_t;
endpackage : pio_pkg

// [tb/pio_io_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pio_io_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_rd,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_data,
    input  wire logic [1:0] i_wait,
    output logic [7:0]      o_rdata,
    output logic            o_ready
);
    logic [1:0] cnt = 2'h0;
    initial o_ready = 1'b0;
    initial o_rdata = 8'h00;
    // Answer after i_wait cycles; data holds only with ready
    always @(posedge i_core_clk) begin
        o_ready <= 1'b0;
        o_rdata <= ~o_rdata;
        cnt <= 2'h0;
        if ((i_rd || i_wr) && !o_ready && cnt != i_wait) cnt <= cnt + 2'h1;
        if ((i_rd || i_wr) && !o_ready && cnt == i_wait) begin
            o_ready <= 1'b1;
            o_rdata <= i_data;
        end
    end
endmodule : pio_io_model
`default_nettype wire

// [tb/port_io_and_condition_flags_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch %0t %h %h", $time, a, b); end end
module port_io_and_condition_flags_tb_top;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, mv = 0, mrdy = 1;
    logic        ack, rd, wr, rdy, mr, omv, cct;
    logic [3:0]  adr = 0;
    logic [31:0] wd = 0, q, f;
    logic [15:0] ia, ma;
    logic [7:0]  iw, ir, omd, a, b, d, m, md = 0, iod = 0;
    logic [1:0]  wt = 0;
    logic [23:0] ioq[$], memq[$];
    int          fail_count = 0, tests_run = 0, cpos[4] = '{6, 0, 2, 7};
    pio_pkg::pio_cc_t cc = pio_pkg::PIO_CC_Z;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (rdy) ioq.push_back({ia, iw});
        if (omv && mrdy) memq.push_back({ma, omd});
    end
    pio_core i_dut (.i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_dat(wd), .i_wb_sel(4'hf), .o_wb_dat(q), .o_wb_ack(ack),
        .o_io_addr(ia), .o_io_wdata(iw), .o_io_rd(rd), .o_io_wr(wr), .i_io_rdata(ir),
        .i_io_ready(rdy), .i_mem_valid(mv), .o_mem_ready(mr), .i_mem_data(md), .o_mem_valid(omv),
        .i_mem_ready(mrdy), .o_mem_data(omd), .o_mem_addr(ma), .i_cc_sel(cc), .o_cc_true(cct));
    pio_io_model i_dev (.i_core_clk(clk), .i_rd(rd), .i_wr(wr), .i_data(iod), .i_wait(wt),
        .o_rdata(ir), .o_ready(rdy));
    task automatic give_verdict;
        if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic hold(input bit use_mr);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((use_mr ? mr : ack) !== 1'b1 && n < 400);
        if ((use_mr ? mr : ack) !== 1'b1) begin
            fail_count++;
            give_verdict();
        end
    endtask : hold
    task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] dt);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wd <= dt;
        hold(1'b0);
        f = q;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic run(input logic [31:0] c);
        int n;
        n = 0;
        wb(1'b1, 4'h4, c);
        do begin
            wb(1'b0, 4'h5, 0);
            n++;
        end while (f[0] !== 1'b0 && n < 400);
        `CHK(f[0], 1'b0)
        if (f[0] !== 1'b0) give_verdict();
    endtask : run
    task automatic push(input logic [7:0] v);
        mv <= 1'b1;
        md <= v;
        hold(1'b1);
        mv <= 1'b0;
        @(posedge clk);
    endtask : push
    function automatic logic [7:0] exp_f(input int op, input logic [7:0] x, input logic [7:0] y);
        logic [8:0] r;
        logic       h, v;
        r = (op == 1) ? x - y : x + y;
        h = (op == 1) ? x[3:0] < y[3:0] : (x[3:0] + y[3:0]) > 15;
        v = (x[7] ^ y[7] ^ (op == 0)) && (r[7] != x[7]);
        if (op > 1) r = (op == 2) ? x & y : (op == 3) ? x | y : x ^ y;
        if (op > 1) v = ~^r[7:0];
        return {r[7], r[7:0] == 0, 1'b0, h, 1'b0, v, op == 1, r[8]};
    endfunction : exp_f
    initial begin
        a = 8'($urandom(12124));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(1'b0, 4'h0, 0);
        `CHK(f[7:0], 8'h00)
        wb(1'b0, 4'hf, 0);
        `CHK(f, 32'h0)
        wb(1'b1, 4'h1, 32'hff);
        wb(1'b0, 4'h1, 0);
        `CHK(f[7:0], 8'hd7)
        wb(1'b1, 4'h6, 32'h1);
        run({8'h00, 8'h80, 12'h000, 4'(pio_pkg::PIO_OP_LD_IR)});
        wb(1'b0, 4'h0, 0);
        `CHK({f[7:6], f[2]}, 3'b101)
        for (int i = 0; i < 10; i++) begin
            a = (i == 0) ? 8'h78 : 8'($urandom);
            b = (i == 0) ? 8'h69 : 8'($urandom);
            m = (i % 5 > 1) ? 8'hef : 8'hff;
            wb(1'b1, 4'h2, {a, 24'h0});
            run({8'h00, b, 9'h000, 3'(i % 5), 4'(pio_pkg::PIO_OP_ALU)});
            wb(1'b0, 4'h0, 0);
            `CHK(f[7:0] & m, exp_f(i % 5, a, b) & m)
            for (int c = 0; c < 4; c++) begin
                cc <= pio_pkg::pio_cc_t'(c);
                @(posedge clk);
                `CHK(cct, f[cpos[c]])
            end
        end
        for (int i = 0; i < 2; i++) begin
            a = 8'($urandom);
            b = 8'($urandom);
            wt <= 2'($urandom);
            wb(1'b1, 4'h2, {a, 16'h0, b});
            run({8'h00, b, 12'h000, 4'(i ? pio_pkg::PIO_OP_OUT_IMM : pio_pkg::PIO_OP_IN_IMM)});
            `CHK(ioq[$][23:8], {a, b})
        end
        d = 8'($urandom);
        iod <= d;
        wb(1'b1, 4'h2, 32'h5a123400);
        run({19'h0, 3'h6, 6'h00, 4'(pio_pkg::PIO_OP_IN_REG)});
        `CHK(ioq[$][23:8], 16'h1234)
        wb(1'b0, 4'h0, 0);
        `CHK(f[7:1], {d[7], d == 0, 3'b000, ~^d, 1'b0})
        wb(1'b0, 4'h2, 0);
        `CHK(f[31:24], 8'h5a)
        for (int i = 0; i < 16; i++) push(8'ha0 + 8'(i));
        `CHK(mr, 1'b0)
        wt <= 2'h3;
        wb(1'b1, 4'h3, 32'h0100);
        wb(1'b1, 4'h2, 32'h00104400);
        ioq.delete();
        run({22'h0, 2'b11, 4'h0, 4'(pio_pkg::PIO_OP_BLK_OUT)});
        `CHK(ioq.size(), 16)
        for (int i = 0; i < 16; i++) `CHK(ioq[i], {8'(16 - i), 8'h44, 8'ha0 + 8'(i)})
        wb(1'b0, 4'h0, 0);
        `CHK({f[6], f[1]}, 2'b11)
        wb(1'b0, 4'h3, 0);
        `CHK(f[15:0], 16'h00f0)
        d = 8'($urandom);
        iod <= d;
        wb(1'b1, 4'h3, 32'h0200);
        wb(1'b1, 4'h2, 32'h00022100);
        run({28'h0, 4'(pio_pkg::PIO_OP_BLK_IN)});
        `CHK(memq[$], {16'h0200, d})
        wb(1'b0, 4'h0, 0);
        `CHK(f[6], 1'b0)
        give_verdict();
    end
endmodule : port_io_and_condition_flags_tb_top
`default_nettype wire
